// File: common/udr_pkg.sv
// Purpose: Shared constants for the DMA ready signalling block of the serial element.
// Assumes: One clock domain, core_clk at 50 MHz, asynchronous active-high reset.
// Notes:   Occupancy counts cover the FIFO, or the holding register in character mode.
`default_nettype none

package udr_pkg;

	// Depth of the receive and transmit FIFOs in characters.
	localparam int unsigned FIFO_DEPTH    = 16;
	// Width of an occupancy count that can hold the value FIFO_DEPTH.
	localparam int unsigned COUNT_W       = 5;
	// Number of flip-flops that every pin input passes before it is used.
	localparam int unsigned SYNC_STAGES   = 2;
	// Number of host strobe and select pins that are synchronised.
	localparam int unsigned HOST_PINS     = 5;

	// Bit positions of the host pins inside the synchroniser vector.
	localparam int unsigned PIN_SELECT    = 0;
	localparam int unsigned PIN_WR_LOW_N  = 1;
	localparam int unsigned PIN_WR_HIGH   = 2;
	localparam int unsigned PIN_RD_LOW_N  = 3;
	localparam int unsigned PIN_RD_HIGH   = 4;

	// Reset values: request outputs idle high, the line idles at the marking level.
	localparam logic RX_REQ_N_RESET  = 1'h1;
	localparam logic TX_REQ_N_RESET  = 1'h1;
	localparam logic MARK_LEVEL      = 1'h1;
	localparam logic STROBE_RESET    = 1'h0;
	// Reset value of the synchroniser: strobes and select idle inactive.
	localparam logic [HOST_PINS-1:0] PIN_IDLE = 5'h0A;

	// The two signalling types of the DMA ready outputs.
	typedef enum logic [0:0] {
		UDR_DMA_SINGLE = 1'b0,
		UDR_DMA_MULTI  = 1'b1
	} udr_dma_mode_t;

endpackage : udr_pkg

`default_nettype wire

// File: rtl/udr_dma_ready.sv
// Purpose: DMA ready outputs, host strobe decode and reset level of the serial output.
// Assumes: Counts, trigger, time-out and control bits come from logic on core_clk.
// Notes:   Only the host pins are synchronised; every other input is on core_clk.
`timescale 1ns/100ps
`default_nettype none

module udr_dma_ready #(
	parameter int unsigned DEPTH = udr_pkg::FIFO_DEPTH,
	parameter int unsigned CW    = udr_pkg::COUNT_W
) (
	input  wire logic          core_clk,
	input  wire logic          sys_rst,
	input  wire logic          chip_select,
	input  wire logic          write_strobe_low_n,
	input  wire logic          write_strobe_high,
	input  wire logic          read_strobe_low_n,
	input  wire logic          read_strobe_high,
	input  wire logic          fifo_enable_bit,
	input  wire logic          dma_mode_select_bit,
	input  wire logic [CW-1:0] rx_char_count,
	input  wire logic          rx_trigger_hit,
	input  wire logic          rx_timeout_hit,
	input  wire logic [CW-1:0] tx_char_count,
	input  wire logic          tx_serial_bit,
	output logic               rx_dma_request_n,
	output logic               tx_dma_request_n,
	output logic               serial_out,
	output logic               host_write_pulse,
	output logic               host_read_enable
);

	typedef struct packed {
		logic rx_req_n;
		logic tx_req_n;
		logic line;
		logic write_seen;
		logic write_pulse;
		logic read_level;
	} udr_state_t;

	udr_state_t                    state;
	udr_state_t                    next_state;
	logic [udr_pkg::HOST_PINS-1:0] pins_raw;
	logic [udr_pkg::HOST_PINS-1:0] pins;
	udr_pkg::udr_dma_mode_t        dma_mode;
	logic                          write_active;
	logic                          read_active;
	logic                          rx_any;
	logic                          tx_empty;
	logic                          tx_full;

	// Decides the signalling type: multi-transfer only with FIFOs on and the mode bit set.
	function automatic udr_pkg::udr_dma_mode_t pick_mode(input logic fen, input logic dms);
		pick_mode = (fen && dms) ? udr_pkg::UDR_DMA_MULTI : udr_pkg::UDR_DMA_SINGLE;
	endfunction : pick_mode

	// Host pins are asynchronous to core_clk, so they all pass the synchroniser.
	assign pins_raw[udr_pkg::PIN_SELECT]   = chip_select;
	assign pins_raw[udr_pkg::PIN_WR_LOW_N] = write_strobe_low_n;
	assign pins_raw[udr_pkg::PIN_WR_HIGH]  = write_strobe_high;
	assign pins_raw[udr_pkg::PIN_RD_LOW_N] = read_strobe_low_n;
	assign pins_raw[udr_pkg::PIN_RD_HIGH]  = read_strobe_high;

	udr_sync #(
		.WIDTH (udr_pkg::HOST_PINS),
		.IDLE  (udr_pkg::PIN_IDLE)
	) u_pin_sync (
		.core_clk (core_clk),
		.sys_rst  (sys_rst),
		.pin_in   (pins_raw),
		.pin_sync (pins)
	);

	// Either polarity of strobe qualifies an access; the unused one must sit inactive.
	assign write_active = pins[udr_pkg::PIN_SELECT] &&
		(!pins[udr_pkg::PIN_WR_LOW_N] || pins[udr_pkg::PIN_WR_HIGH]);
	assign read_active  = pins[udr_pkg::PIN_SELECT] &&
		(!pins[udr_pkg::PIN_RD_LOW_N] || pins[udr_pkg::PIN_RD_HIGH]);

	// Occupancy decode shared by both request paths.
	assign dma_mode = pick_mode(fifo_enable_bit, dma_mode_select_bit);
	assign rx_any   = (rx_char_count != '0);
	assign tx_empty = (tx_char_count == '0);
	assign tx_full  = (tx_char_count >= CW'(DEPTH));

	// Next state of both requests, the line and the strobe decode.
	always_comb begin
		next_state = state;
		unique case (dma_mode)
			udr_pkg::UDR_DMA_SINGLE: begin
				// One character at a time: the controller waits on each request.
				next_state.rx_req_n = !rx_any;
				next_state.tx_req_n = !tx_empty;
			end
			udr_pkg::UDR_DMA_MULTI: begin
				// Once raised, the receive request stays until the burst drains the FIFO.
				if (!state.rx_req_n) begin
					next_state.rx_req_n = !rx_any;
				end else begin
					next_state.rx_req_n = !((rx_trigger_hit || rx_timeout_hit) && rx_any);
				end
				next_state.tx_req_n = tx_full;
			end
		endcase
		next_state.line        = tx_serial_bit;
		next_state.write_seen  = write_active;
		next_state.write_pulse = write_active && !state.write_seen;
		next_state.read_level  = read_active;
	end

	// Reset puts the line at marking and both requests idle.
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state.rx_req_n    <= udr_pkg::RX_REQ_N_RESET;
			state.tx_req_n    <= udr_pkg::TX_REQ_N_RESET;
			state.line        <= udr_pkg::MARK_LEVEL;
			state.write_seen  <= udr_pkg::STROBE_RESET;
			state.write_pulse <= udr_pkg::STROBE_RESET;
			state.read_level  <= udr_pkg::STROBE_RESET;
		end else begin
			state <= next_state;
		end
	end

	assign rx_dma_request_n = state.rx_req_n;
	assign tx_dma_request_n = state.tx_req_n;
	assign serial_out       = state.line;
	assign host_write_pulse = state.write_pulse;
	assign host_read_enable = state.read_level;

	// Single-transfer receive request follows occupancy one cycle later.
	// The sampled reset keeps out the attempt at the release edge, where the
	// request still shows its reset value one cycle later.
	property p_rx_single;
		@(posedge core_clk) disable iff (sys_rst)
		(!sys_rst && dma_mode == udr_pkg::UDR_DMA_SINGLE)
			|=> (rx_dma_request_n == !$past(rx_any));
	endproperty
	a_rx_single: assert property (p_rx_single)
		else $error("Single-mode receive request does not follow occupancy.");

	// Character mode never uses the burst behaviour even with the mode bit set.
	property p_char_mode;
		@(posedge core_clk) disable iff (sys_rst)
		(!fifo_enable_bit && !rx_any) |=> rx_dma_request_n;
	endproperty
	a_char_mode: assert property (p_char_mode)
		else $error("Character mode receive request stayed low when empty.");

	// Burst receive request goes low on trigger or time-out with data held.
	property p_rx_burst_start;
		@(posedge core_clk) disable iff (sys_rst)
		(dma_mode == udr_pkg::UDR_DMA_MULTI && rx_any && (rx_trigger_hit || rx_timeout_hit))
			|=> !rx_dma_request_n;
	endproperty
	a_rx_burst_start: assert property (p_rx_burst_start)
		else $error("Burst receive request not raised at trigger or time-out.");

	// Burst receive request stays high below the trigger without a time-out.
	property p_rx_burst_quiet;
		@(posedge core_clk) disable iff (sys_rst)
		(dma_mode == udr_pkg::UDR_DMA_MULTI && rx_dma_request_n &&
			!rx_trigger_hit && !rx_timeout_hit) |=> rx_dma_request_n;
	endproperty
	a_rx_burst_quiet: assert property (p_rx_burst_quiet)
		else $error("Burst receive request raised before trigger.");

	// An active burst request is held while data remains, then released at empty.
	property p_rx_burst_hold;
		@(posedge core_clk) disable iff (sys_rst)
		(dma_mode == udr_pkg::UDR_DMA_MULTI && !rx_dma_request_n)
			|=> (rx_dma_request_n == !$past(rx_any));
	endproperty
	a_rx_burst_hold: assert property (p_rx_burst_hold)
		else $error("Burst receive request not held until empty.");

	// Single-transfer transmit request is low exactly while the transmitter is empty.
	property p_tx_single;
		@(posedge core_clk) disable iff (sys_rst)
		(!sys_rst && dma_mode == udr_pkg::UDR_DMA_SINGLE)
			|=> (tx_dma_request_n == !$past(tx_empty));
	endproperty
	a_tx_single: assert property (p_tx_single)
		else $error("Single-mode transmit request does not follow empty.");

	// Burst transmit request is low exactly while room remains.
	property p_tx_burst;
		@(posedge core_clk) disable iff (sys_rst)
		(!sys_rst && dma_mode == udr_pkg::UDR_DMA_MULTI)
			|=> (tx_dma_request_n == $past(tx_full));
	endproperty
	a_tx_burst: assert property (p_tx_burst)
		else $error("Burst transmit request does not follow full.");

	// The line is at marking in the first cycle after reset.
	property p_mark_reset;
		@(posedge core_clk)
		$fell(sys_rst) |-> serial_out;
	endproperty
	a_mark_reset: assert property (p_mark_reset)
		else $error("Serial output not at marking after reset.");

	// A write pulse needs a qualified strobe one cycle earlier and lasts one cycle.
	property p_write_pulse;
		@(posedge core_clk) disable iff (sys_rst)
		host_write_pulse |-> $past(write_active) ##1 !host_write_pulse;
	endproperty
	a_write_pulse: assert property (p_write_pulse)
		else $error("Write pulse without a qualified strobe or longer than one cycle.");

	// Read enable follows the qualified read strobe one cycle later.
	property p_read_level;
		@(posedge core_clk) disable iff (sys_rst)
		read_active |=> host_read_enable;
	endproperty
	a_read_level: assert property (p_read_level)
		else $error("Read enable missing for a qualified read strobe.");

endmodule : udr_dma_ready

`default_nettype wire

// File: rtl/udr_sync.sv
// Purpose: Two-stage synchroniser for a vector of host pins.
// Assumes: Each bit is an independent level; no bit relation is kept across the crossing.
// Notes:   The first stage feeds only the second stage.
`timescale 1ns/100ps
`default_nettype none

module udr_sync #(
	parameter int unsigned        WIDTH = udr_pkg::HOST_PINS,
	parameter logic [WIDTH-1:0]   IDLE  = udr_pkg::PIN_IDLE
) (
	input  wire logic             core_clk,
	input  wire logic             sys_rst,
	input  wire logic [WIDTH-1:0] pin_in,
	output logic      [WIDTH-1:0] pin_sync
);

	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] stable;
	} udr_sync_state_t;

	udr_sync_state_t state;
	udr_sync_state_t next_state;

	// The first stage may go metastable, so only the second stage is read outside.
	always_comb begin
		next_state        = state;
		next_state.meta   = pin_in;
		next_state.stable = state.meta;
	end

	// Both stages reset to the idle pin levels.
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state.meta   <= IDLE;
			state.stable <= IDLE;
		end else begin
			state <= next_state;
		end
	end

	assign pin_sync = state.stable;

endmodule : udr_sync

`default_nettype wire

// File: verif/udr_dma_ready_tb.sv
// Purpose: Self-checking bench for the DMA ready outputs and the host strobe decode.
// Assumes: Result of inputs sampled at one edge is visible just after that edge.
// Notes:   Strobes pass a two-flop synchroniser, so accesses are held several cycles.
`timescale 1ns/100ps
`default_nettype none

module udr_dma_ready_tb;
	localparam int unsigned CW = udr_pkg::COUNT_W;
	logic          core_clk, sys_rst, fe, dm, tg, to, sb;
	logic [CW-1:0] rc, tc;
	logic          cs, wl_n, wh, rl_n, rh;
	logic          rx_n, tx_n, s_out, wr_p, rd_en;
	int            n_errors, n_tests, n_wp;

	// Clock, reset and inputs that would make both requests active, from time zero.
	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end
	initial begin
		sys_rst = 1'b1; fe = 1'b0; dm = 1'b0; tg = 1'b0; to = 1'b0; sb = 1'b0;
		rc = 5'h03; tc = 5'h00; n_errors = 0; n_tests = 0; n_wp = 0;
	end

	udr_host_model udr_host_model_i (.core_clk(core_clk), .chip_select(cs),
		.write_strobe_low_n(wl_n), .write_strobe_high(wh),
		.read_strobe_low_n(rl_n), .read_strobe_high(rh));

	udr_dma_ready udr_dma_ready_i (.core_clk(core_clk), .sys_rst(sys_rst), .chip_select(cs),
		.write_strobe_low_n(wl_n), .write_strobe_high(wh), .read_strobe_low_n(rl_n),
		.read_strobe_high(rh), .fifo_enable_bit(fe), .dma_mode_select_bit(dm),
		.rx_char_count(rc), .rx_trigger_hit(tg), .rx_timeout_hit(to), .tx_char_count(tc),
		.tx_serial_bit(sb), .rx_dma_request_n(rx_n), .tx_dma_request_n(tx_n),
		.serial_out(s_out), .host_write_pulse(wr_p), .host_read_enable(rd_en));

	// Pulses are counted here because a strobe is held across many edges.
	// The falling edge is used so the count never races the flop that launches the pulse.
	always @(negedge core_clk) begin
		if (wr_p === 1'b1) n_wp++;
	end

	task automatic close_out();
		if (n_errors == 0 && n_tests > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : close_out

	task automatic chk(input logic got, input logic exp);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic chk_n(input int got, input int exp);
		n_tests++;
		if (got != exp) begin
			n_errors++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_n

	// One step: drive at an edge, let the next edge sample it, then look just after.
	task automatic drv(input logic f, d, input logic [CW-1:0] r, t, input logic g, o, s);
		@(posedge core_clk);
		fe <= f; dm <= d; rc <= r; tc <= t; tg <= g; to <= o; sb <= s;
		@(posedge core_clk);
		#1;
	endtask : drv

	// Single-transfer signalling for character mode and for FIFO mode with mode bit clear.
	task automatic t_single();
		logic [1:0] m;
		for (int k = 0; k < 3; k++) begin
			m = k[1:0];
			drv(m[1], m[0], 5'h01, 5'h00, 1'b0, 1'b0, 1'b0);
			chk(rx_n, 1'b0);
			chk(tx_n, 1'b0);
			drv(m[1], m[0], 5'h00, 5'h01, 1'b1, 1'b1, 1'b0);
			chk(rx_n, 1'b1);
			chk(tx_n, 1'b1);
			drv(m[1], m[0], 5'h00, 5'h0F, 1'b0, 1'b0, 1'b0);
			chk(tx_n, 1'b1);
		end
	endtask : t_single

	// Multi-transfer receive: start on trigger or time-out, hold until empty.
	task automatic t_multi_rx();
		drv(1'b1, 1'b1, 5'h05, 5'h10, 1'b0, 1'b0, 1'b0);
		chk(rx_n, 1'b1);
		drv(1'b1, 1'b1, 5'h00, 5'h10, 1'b1, 1'b0, 1'b0);
		chk(rx_n, 1'b1);
		drv(1'b1, 1'b1, 5'h05, 5'h10, 1'b1, 1'b0, 1'b0);
		chk(rx_n, 1'b0);
		drv(1'b1, 1'b1, 5'h03, 5'h10, 1'b0, 1'b0, 1'b0);
		chk(rx_n, 1'b0);
		drv(1'b1, 1'b1, 5'h01, 5'h10, 1'b0, 1'b0, 1'b0);
		chk(rx_n, 1'b0);
		drv(1'b1, 1'b1, 5'h00, 5'h10, 1'b0, 1'b0, 1'b0);
		chk(rx_n, 1'b1);
		drv(1'b1, 1'b1, 5'h02, 5'h10, 1'b0, 1'b1, 1'b0);
		chk(rx_n, 1'b0);
		drv(1'b1, 1'b1, 5'h00, 5'h10, 1'b0, 1'b0, 1'b0);
		chk(rx_n, 1'b1);
	endtask : t_multi_rx

	// Multi-transfer transmit: request stands until the FIFO is full.
	task automatic t_multi_tx();
		drv(1'b1, 1'b1, 5'h00, 5'h0F, 1'b0, 1'b0, 1'b1);
		chk(tx_n, 1'b0);
		chk(s_out, 1'b1);
		drv(1'b1, 1'b1, 5'h00, 5'h10, 1'b0, 1'b0, 1'b0);
		chk(tx_n, 1'b1);
		chk(s_out, 1'b0);
		drv(1'b1, 1'b1, 5'h00, 5'h00, 1'b0, 1'b0, 1'b1);
		chk(tx_n, 1'b0);
	endtask : t_multi_tx

	// Each strobe gives one pulse or a level while selected; nothing without select.
	task automatic t_host();
		for (int k = 0; k < 2; k++) begin
			n_wp = 0;
			udr_host_model_i.set_pins(1'b1, 4'h1 << k);
			repeat (6) @(posedge core_clk);
			udr_host_model_i.set_pins(1'b0, 4'h0);
			repeat (5) @(posedge core_clk);
			chk_n(n_wp, 1);
			udr_host_model_i.set_pins(1'b1, 4'h4 << k);
			repeat (4) @(posedge core_clk);
			#1;
			chk(rd_en, 1'b1);
			udr_host_model_i.set_pins(1'b0, 4'h4 << k);
			repeat (4) @(posedge core_clk);
			#1;
			chk(rd_en, 1'b0);
			chk_n(n_wp, 1);
		end
		// A write strobe while deselected must give no pulse.
		udr_host_model_i.set_pins(1'b0, 4'h1);
		repeat (5) @(posedge core_clk);
		chk_n(n_wp, 1);
	endtask : t_host

	// The whole run is some 95 cycles, so a 100 us limit means a hang.
	initial begin
		#100us;
		n_errors++;
		close_out();
	end

	// Reset checks happen with inputs that would otherwise make requests active.
	initial begin
		@(posedge core_clk);
		#1;
		chk(s_out, 1'b1);
		chk(rx_n, 1'b1);
		chk(tx_n, 1'b1);
		@(posedge core_clk);
		sys_rst <= 1'b0;
		t_single();
		t_multi_rx();
		t_multi_tx();
		t_host();
		close_out();
	end
endmodule : udr_dma_ready_tb

`default_nettype wire

// File: verif/udr_host_model.sv
// Purpose: Host bus model that drives the select and the four strobe pins.
// Assumes: Pins change by non-blocking assignment at the rising edge of core_clk.
// Notes:   Only the strobes named in an access are active; the rest stay idle.
`timescale 1ns/100ps
`default_nettype none

module udr_host_model (
	input  wire logic core_clk,
	output logic      chip_select,
	output logic      write_strobe_low_n,
	output logic      write_strobe_high,
	output logic      read_strobe_low_n,
	output logic      read_strobe_high
);

	// Pins start idle so that no access is seen while reset is released.
	initial begin
		chip_select        = 1'b0;
		write_strobe_low_n = 1'b1;
		write_strobe_high  = 1'b0;
		read_strobe_low_n  = 1'b1;
		read_strobe_high   = 1'b0;
	end

	// Bit 0 low write, 1 high write, 2 low read, 3 high read; unused ones are held inactive.
	task automatic set_pins(input logic sel, input logic [3:0] act);
		@(posedge core_clk);
		chip_select        <= sel;
		write_strobe_low_n <= ~act[0];
		write_strobe_high  <= act[1];
		read_strobe_low_n  <= ~act[2];
		read_strobe_high   <= act[3];
	endtask : set_pins

endmodule : udr_host_model

`default_nettype wire
